/* hdl/fhsdr_pkg.sv */
// Package of offsets, field positions, reset values and timing counts for the host register slice.
`default_nettype none
package fhsdr_pkg;
  // ---------------------------------------------------------------
  // Register offsets (word index; byte address is four times it).
  // ---------------------------------------------------------------
  localparam logic [11:0] ofs_main_status       = 12'h3f4;
  localparam logic [11:0] ofs_command_data_port = 12'h3f5;
  localparam logic [11:0] ofs_input_status      = 12'h3f7;
  localparam logic [11:0] ofs_rate_control      = 12'h3f7;
  localparam logic [11:0] ofs_write_rate        = 12'h3f4;
  localparam logic [11:0] ofs_core_ctrl         = 12'h3f0;
  localparam logic [11:0] ofs_core_stat         = 12'h3f1;
  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int ms_cmd_busy   = 4;
  localparam int ms_polled     = 5;
  localparam int ms_direction  = 6;
  localparam int ms_request    = 7;
  localparam int is_media      = 7;
  localparam int rc_precomp    = 2;
  localparam int dor_dma_gate  = 3;
  // ---------------------------------------------------------------
  // Reset values and codes.
  // ---------------------------------------------------------------
  localparam logic [1:0] rate_500k   = 2'h0;
  localparam logic [1:0] rate_300k   = 2'h1;
  localparam logic [1:0] rate_250k   = 2'h2;
  localparam logic [1:0] rate_1m     = 2'h3;
  localparam logic [1:0] rate_reset  = rate_250k;
  localparam logic [7:0] fill_byte   = 8'h00;
  localparam logic [1:0] mode_a      = 2'h0;
  localparam logic [1:0] mode_b      = 2'h1;
  localparam logic [1:0] mode_c      = 2'h2;
  localparam logic [7:0] op_seek     = 8'h0f;
  localparam logic [7:0] op_recal    = 8'h07;
  localparam logic [7:0] op_specify  = 8'h03;
  localparam logic [7:0] op_configure = 8'h13;
  localparam logic [7:0] op_read     = 8'h06;
  localparam logic [7:0] op_write    = 8'h05;
  localparam logic [4:0] fifo_depth  = 5'h10;
  localparam logic [2:0] result_len  = 3'h7;
  // ---------------------------------------------------------------
  // Timing: byte period at each rate and service margin.
  // ---------------------------------------------------------------
  localparam int clk_mhz       = 125;
  localparam int byte_ns_1m    = 8000;
  localparam int byte_ns_500k  = 16000;
  localparam int byte_ns_300k  = 26667;
  localparam int byte_ns_250k  = 32000;
  localparam int margin_ns     = 1500;
  localparam int byte_cyc_1m   = byte_ns_1m * clk_mhz / 1000;
  localparam int byte_cyc_500k = byte_ns_500k * clk_mhz / 1000;
  localparam int byte_cyc_300k = byte_ns_300k * clk_mhz / 1000;
  localparam int byte_cyc_250k = byte_ns_250k * clk_mhz / 1000;
endpackage
`default_nettype wire

/* hdl/fhsdr_fifo_if.sv */
// Interface carrying the data FIFO controls between the core and its byte store.
`default_nettype none
interface fhsdr_fifo_if;
  logic       push;
  logic       pop;
  logic       flush;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [4:0] count;
  modport owner (output push, output pop, output flush, output wdata,
                 input rdata, input count);
  modport store (input push, input pop, input flush, input wdata,
                 output rdata, output count);
endinterface
`default_nettype wire

/* hdl/fhsdr_fifo.sv */
// Sixteen-byte data FIFO held in flip-flops.
`default_nettype none
module fhsdr_fifo (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Controls.
  fhsdr_fifo_if.store     f
);
  logic [7:0] mem [16];
  logic [3:0] rd_ptr;
  logic [3:0] wr_ptr;
  logic [4:0] cnt;

  assign f.rdata = mem[rd_ptr];
  assign f.count = cnt;

  always_ff @(posedge core_clk) begin
    if (f.push && cnt != fhsdr_pkg::fifo_depth) begin
      mem[wr_ptr] <= f.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || f.flush) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      cnt    <= 5'h00;
    end else begin
      if (f.push && cnt != fhsdr_pkg::fifo_depth) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (f.pop && cnt != 5'h00) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      cnt <= cnt + 5'((f.push && cnt != fhsdr_pkg::fifo_depth) ? 1 : 0)
                 - 5'((f.pop && cnt != 5'h00) ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

/* hdl/fhsdr_byte_timer.sv */
// Byte-period enable divider for the selected data rate.
`default_nettype none
module fhsdr_byte_timer (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] rate,
  // Output.
  output logic            tick
);
  logic [12:0] cnt;
  logic [12:0] limit;

  always_comb begin
    case (rate)
      fhsdr_pkg::rate_1m:   limit = 13'(fhsdr_pkg::byte_cyc_1m - 1);
      fhsdr_pkg::rate_500k: limit = 13'(fhsdr_pkg::byte_cyc_500k - 1);
      fhsdr_pkg::rate_300k: limit = 13'(fhsdr_pkg::byte_cyc_300k - 1);
      default:              limit = 13'(fhsdr_pkg::byte_cyc_250k - 1);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      cnt  <= 13'h0000;
      tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt  <= 13'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 13'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hdl/fhsdr_regs.sv */
// Host register slice of the floppy controller: status, data port, input status and rate.
`default_nettype none
module fhsdr_regs (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave.
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Drive cable and configuration.
  input  wire logic        media_changed,
  input  wire logic [1:0]  layout_mode,
  input  wire logic        dma_gate,
  input  wire logic        soft_reset,
  // Disk side data stream.
  input  wire logic        disk_byte_in_valid,
  input  wire logic [7:0]  disk_byte_in,
  output logic             disk_byte_out_valid,
  output logic [7:0]       disk_byte_out,
  output logic             disk_crc_fill,
  // Outputs.
  output logic             density_pin,
  output logic [1:0]       rate_select,
  output logic             data_bus_lo_oe_n
);
  // ---------------------------------------------------------------
  // Command phase tracking.
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {st_idle, st_params, st_exec, st_drain, st_result} fhsdr_phase_e;

  fhsdr_phase_e phase;
  logic [7:0]   opcode;
  logic [3:0]   params_left;
  logic [2:0]   results_left;
  logic [3:0]   exec_left;
  logic         polled_mode;
  logic         fifo_enabled;
  logic         precomp_off;
  logic         fault;
  logic         tick;
  logic         acc_pending;
  logic         is_rd;
  logic         is_wr;
  logic [11:0]  idx;
  logic         data_rd;
  logic         data_wr;
  logic         req_ready;
  logic         dir_read;
  logic [7:0]   result_byte;
  logic         fifo_full;
  fhsdr_fifo_if fif ();

  function automatic logic [3:0] param_count(input logic [7:0] op);
    case (op)
      fhsdr_pkg::op_seek:      param_count = 4'h2;
      fhsdr_pkg::op_recal:     param_count = 4'h1;
      fhsdr_pkg::op_specify:   param_count = 4'h2;
      fhsdr_pkg::op_configure: param_count = 4'h3;
      fhsdr_pkg::op_read:      param_count = 4'h8;
      fhsdr_pkg::op_write:     param_count = 4'h8;
      default:                 param_count = 4'h0;
    endcase
  endfunction

  function automatic logic has_exec(input logic [7:0] op);
    has_exec = (op == fhsdr_pkg::op_read) || (op == fhsdr_pkg::op_write);
  endfunction

  function automatic logic has_result(input logic [7:0] op);
    has_result = has_exec(op);
  endfunction

  assign idx     = avs_address[13:2];
  assign is_rd   = avs_read && acc_pending;
  assign is_wr   = avs_write && acc_pending && avs_byteenable[0];
  assign data_rd = is_rd && idx == fhsdr_pkg::ofs_command_data_port;
  assign data_wr = is_wr && idx == fhsdr_pkg::ofs_command_data_port;
  // With the FIFO off, one held byte already counts as full.
  assign fifo_full = fif.count >= (fifo_enabled ? fhsdr_pkg::fifo_depth : 5'h01);

  // Request and direction from the phase.
  always_comb begin
    req_ready = 1'b0;
    dir_read  = 1'b0;
    case (phase)
      st_idle, st_params: req_ready = 1'b1;
      st_exec: begin
        dir_read  = (opcode == fhsdr_pkg::op_read);
        req_ready = dir_read ? (fif.count != 5'h00)
                             : !fifo_full;
      end
      st_drain: begin
        dir_read  = 1'b1;
        req_ready = fif.count != 5'h00;
      end
      st_result: begin
        dir_read  = 1'b1;
        req_ready = 1'b1;
      end
      default: req_ready = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus slave: one wait cycle, answer on the second edge.
  // ---------------------------------------------------------------
  // Waitrequest is kept as a registered inverse of the pending flag so the port leaves a flop.
  always_ff @(posedge core_clk) begin
    if (sys_rst || acc_pending) begin
      acc_pending     <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      acc_pending     <= avs_read || avs_write;
      avs_waitrequest <= !(avs_read || avs_write);
    end
  end

  assign result_byte = {fault, 4'h0, results_left};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      avs_readdata     <= 32'h0000_0000;
      avs_response     <= 2'h0;
      data_bus_lo_oe_n <= 1'b0;
    end else if (avs_read && !acc_pending) begin
      avs_readdata     <= 32'h0000_0000;
      data_bus_lo_oe_n <= 1'b0;
      case (idx)
        fhsdr_pkg::ofs_main_status: begin
          avs_readdata[fhsdr_pkg::ms_request]   <= req_ready;
          avs_readdata[fhsdr_pkg::ms_direction] <= dir_read;
          avs_readdata[fhsdr_pkg::ms_polled]    <= polled_mode && phase == st_exec;
          avs_readdata[fhsdr_pkg::ms_cmd_busy]  <= phase != st_idle;
        end
        fhsdr_pkg::ofs_command_data_port: begin
          avs_readdata[7:0] <= (phase == st_result) ? result_byte : fif.rdata;
        end
        fhsdr_pkg::ofs_input_status: begin
          avs_readdata[fhsdr_pkg::is_media] <= !media_changed;
          case (layout_mode)
            fhsdr_pkg::mode_b: begin
              avs_readdata[6:3] <= 4'hf;
              avs_readdata[2:1] <= rate_select;
              avs_readdata[0]   <= !(rate_select == fhsdr_pkg::rate_500k ||
                                     rate_select == fhsdr_pkg::rate_1m);
            end
            fhsdr_pkg::mode_c: begin
              avs_readdata[fhsdr_pkg::dor_dma_gate] <= dma_gate;
              avs_readdata[fhsdr_pkg::rc_precomp]   <= precomp_off;
              avs_readdata[1:0]                     <= rate_select;
            end
            default: data_bus_lo_oe_n <= 1'b1;
          endcase
        end
        fhsdr_pkg::ofs_core_stat: begin
          avs_readdata[7:0] <= {fifo_enabled, fault, polled_mode, 2'h0, 3'(phase)};
        end
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Rate, precompensation and density.
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rate_select <= fhsdr_pkg::rate_reset;
    end else if (is_wr && (idx == fhsdr_pkg::ofs_rate_control ||
                           idx == fhsdr_pkg::ofs_write_rate)) begin
      rate_select <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      precomp_off <= 1'b0;
    end else if (is_wr && idx == fhsdr_pkg::ofs_rate_control &&
                 layout_mode == fhsdr_pkg::mode_c) begin
      precomp_off <= avs_writedata[fhsdr_pkg::rc_precomp];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      density_pin <= 1'b1;
    end else begin
      density_pin <= (rate_select == fhsdr_pkg::rate_500k ||
                      rate_select == fhsdr_pkg::rate_1m);
    end
  end

  // ---------------------------------------------------------------
  // Command sequencer.
  // ---------------------------------------------------------------
  fhsdr_byte_timer u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (phase == st_exec),
    .rate     (rate_select),
    .tick     (tick)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst || soft_reset) begin
      phase        <= st_idle;
      opcode       <= 8'h00;
      params_left  <= 4'h0;
      results_left <= 3'h0;
      exec_left    <= 4'h0;
      fault        <= 1'b0;
    end else begin
      case (phase)
        st_idle: if (data_wr) begin
          opcode      <= avs_writedata[7:0];
          params_left <= param_count(avs_writedata[7:0]);
          fault       <= 1'b0;
          phase       <= (param_count(avs_writedata[7:0]) == 4'h0) ? st_idle : st_params;
        end
        st_params: if (data_wr) begin
          params_left <= params_left - 4'h1;
          if (params_left == 4'h1) begin
            exec_left <= 4'hf;
            if (has_exec(opcode)) begin
              phase <= st_exec;
            end else if (has_result(opcode)) begin
              phase <= st_result;
            end else begin
              phase <= st_idle;
            end
          end
        end
        st_exec: if (tick) begin
          if (opcode == fhsdr_pkg::op_read && fifo_full) begin
            fault <= 1'b1;
            phase <= st_drain;
          end else if (opcode == fhsdr_pkg::op_write && fif.count == 5'h00) begin
            fault <= 1'b1;
            phase <= st_result;
            results_left <= fhsdr_pkg::result_len;
          end else if (exec_left == 4'h0) begin
            phase <= (opcode == fhsdr_pkg::op_read) ? st_drain : st_result;
            results_left <= fhsdr_pkg::result_len;
          end else begin
            exec_left <= exec_left - 4'h1;
          end
        end
        st_drain: if (fif.count == 5'h00) begin
          phase        <= st_result;
          results_left <= fhsdr_pkg::result_len;
        end
        st_result: if (data_rd) begin
          results_left <= results_left - 3'h1;
          if (results_left == 3'h1) begin
            phase <= st_idle;
          end
        end
        default: phase <= st_idle;
      endcase
    end
  end

  // Configure and specify parameters pick FIFO and polled modes.
  always_ff @(posedge core_clk) begin
    if (sys_rst || soft_reset) begin
      fifo_enabled <= 1'b0;
      polled_mode  <= 1'b0;
    end else if (phase == st_params && data_wr && params_left == 4'h1) begin
      if (opcode == fhsdr_pkg::op_configure) begin
        fifo_enabled <= !avs_writedata[5];
      end
      if (opcode == fhsdr_pkg::op_specify) begin
        polled_mode <= avs_writedata[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Data FIFO and disk byte stream.
  // ---------------------------------------------------------------
  fhsdr_fifo u_fifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .f        (fif)
  );

  assign fif.flush = phase != st_exec && phase != st_drain;
  assign fif.push  = phase == st_exec && !fifo_full && (opcode == fhsdr_pkg::op_read ?
                     disk_byte_in_valid : data_wr);
  assign fif.wdata = opcode == fhsdr_pkg::op_read ? disk_byte_in : avs_writedata[7:0];
  assign fif.pop   = (phase == st_exec || phase == st_drain) &&
                     (opcode == fhsdr_pkg::op_read ? data_rd : tick);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      disk_byte_out_valid <= 1'b0;
      disk_byte_out       <= 8'h00;
      disk_crc_fill       <= 1'b0;
    end else begin
      disk_byte_out_valid <= phase == st_exec && opcode == fhsdr_pkg::op_write && tick;
      disk_byte_out       <= (fif.count == 5'h00) ? fhsdr_pkg::fill_byte : fif.rdata;
      disk_crc_fill       <= phase == st_exec && opcode == fhsdr_pkg::op_write &&
                             tick && fif.count == 5'h00;
    end
  end
endmodule
`default_nettype wire

/* dv/fhsdr_regs_asserts.sv */
// Checker of bus timing, rate select and input status layouts of the register slice.
`default_nettype none
module fhsdr_regs_asserts (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Avalon-MM slave.
  input wire logic [13:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // Cable, configuration and outputs.
  input wire logic        media_changed,
  input wire logic [1:0]  layout_mode,
  input wire logic        dma_gate,
  input wire logic        soft_reset,
  input wire logic        density_pin,
  input wire logic [1:0]  rate_select,
  input wire logic        data_bus_lo_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] a_is = {fhsdr_pkg::ofs_input_status, 2'h0};
  localparam logic [13:0] a_wr = {fhsdr_pkg::ofs_write_rate, 2'h0};
  logic                   rd_is;
  logic                   wr_rt;
  assign rd_is = avs_read && !avs_waitrequest && avs_address == a_is;
  assign wr_rt = avs_write && !avs_waitrequest && avs_byteenable[0]
                 && (avs_address == a_is || avs_address == a_wr);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wait_take_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in one cycle");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  resp_okay_a: assert property (avs_response == 2'h0)
    else $error("response code not okay");
  rate_hard_a: assert property (disable iff (1'b0) sys_rst |=>
    rate_select == fhsdr_pkg::rate_reset && density_pin) else $error("bad hard reset state");
  rate_write_a: assert property (wr_rt |=> rate_select == $past(avs_writedata[1:0]))
    else $error("rate select not taken from last write");
  rate_soft_a: assert property (soft_reset && !avs_write |=> $stable(rate_select))
    else $error("rate select lost on soft reset");
  media_inv_a: assert property (rd_is |-> avs_readdata[7] == !$past(media_changed))
    else $error("media bit not inverted");
  modeb_bits_a: assert property (rd_is && layout_mode == fhsdr_pkg::mode_b |->
    avs_readdata[6:0] == {4'hf, rate_select, rate_select[0] ^ rate_select[1]})
    else $error("bad second layout");
  modec_bits_a: assert property (rd_is && layout_mode == fhsdr_pkg::mode_c |->
    avs_readdata[6:3] == {3'h0, $past(dma_gate)} && avs_readdata[1:0] == rate_select)
    else $error("bad third layout");
  modea_hiz_a: assert property (rd_is && layout_mode == fhsdr_pkg::mode_a |-> data_bus_lo_oe_n)
    else $error("low bits driven in first layout");
endmodule
bind fhsdr_regs fhsdr_regs_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .media_changed(media_changed), .layout_mode(layout_mode),
  .dma_gate(dma_gate), .soft_reset(soft_reset), .density_pin(density_pin),
  .rate_select(rate_select), .data_bus_lo_oe_n(data_bus_lo_oe_n));
`default_nettype wire

/* dv/fhsdr_disk_model.sv */
// Disk-side byte source feeding read-stream bytes at a fixed pace.
`default_nettype none
module fhsdr_disk_model #(
  parameter int period = 40
) (
  // Clock and reset.
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  // Byte stream.
  output logic       byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt;
  logic [7:0] seq;
  // Between bytes the data lines toggle so stale values are never trusted.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt <= 0;
      seq <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      cnt <= (cnt == period - 1) ? 0 : cnt + 1;
      byte_valid <= (cnt == period - 1);
      if (cnt == period - 1) begin
        byte_data <= seq;
        seq <= seq + 8'h01;
      end else begin
        byte_data <= ~byte_data;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_floppy_host_status_data_regs.sv */
// Self-checking bench of the host register slice.
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_floppy_host_status_data_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, sys_rst, avs_read, avs_write, media_changed, dma_gate, soft_reset;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  layout_mode, avs_response, rate_select;
  logic        avs_waitrequest, dbv, dov, crc, density_pin, oe_n, oe_seen;
  logic [7:0]  db, dout, rd, ms;
  int          mismatches, cmp_count;
  localparam logic [13:0] a_ms = {fhsdr_pkg::ofs_main_status, 2'h0};
  localparam logic [13:0] a_dp = {fhsdr_pkg::ofs_command_data_port, 2'h0};
  localparam logic [13:0] a_is = {fhsdr_pkg::ofs_input_status, 2'h0};
  fhsdr_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .media_changed(media_changed), .layout_mode(layout_mode),
    .dma_gate(dma_gate), .soft_reset(soft_reset), .disk_byte_in_valid(dbv),
    .disk_byte_in(db), .disk_byte_out_valid(dov), .disk_byte_out(dout),
    .disk_crc_fill(crc), .density_pin(density_pin), .rate_select(rate_select),
    .data_bus_lo_oe_n(oe_n));
  fhsdr_disk_model u_disk (.core_clk(core_clk), .sys_rst(sys_rst), .byte_valid(dbv),
    .byte_data(db));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    oe_seen = oe_n;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic set_mode(input logic [1:0] m);
    sys_rst <= 1'b1;
    layout_mode <= m;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_rqm();
    do begin
      bus(1'b0, a_ms, 8'h00);
    end while (rd[fhsdr_pkg::ms_request] !== 1'b1);
    ms = rd;
  endtask
  task automatic results();
    wait_rqm();
    `CHK("res dir", 1'b1, ms[fhsdr_pkg::ms_direction])
    bus(1'b0, a_dp, 8'h00);
    `CHK("fault", 1'b1, rd[7])
    repeat (6) bus(1'b0, a_dp, 8'h00);
    wait_rqm();
    `CHK("res end", 1'b0, ms[fhsdr_pkg::ms_cmd_busy])
  endtask
  task automatic t_unmapped();
    bus(1'b1, 14'h0000, 8'h5a);
    bus(1'b0, 14'h0000, 8'h00);
    `CHK("unmapped", 8'h00, rd)
  endtask
  task automatic t_rates();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      media_changed <= c[0];
      bus(1'b1, a_is, {6'h00, c});
      `CHK("rate", c, rate_select)
      bus(1'b0, a_is, 8'h00);
      `CHK("status b", {~c[0], 4'hf, c, c[0] ^ c[1]}, rd)
      bus(1'b1, a_ms, {6'h00, ~c});
      `CHK("rate last", ~c, rate_select)
    end
  endtask
  task automatic t_modec();
    set_mode(fhsdr_pkg::mode_c);
    dma_gate <= 1'b1;
    bus(1'b1, a_is, 8'h05);
    bus(1'b0, a_is, 8'h00);
    `CHK("status c", {~media_changed, 3'h0, 1'b1, 1'b1, 2'h1}, rd)
    soft_reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    soft_reset <= 1'b0;
    dma_gate <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("soft rate", 2'h1, rate_select)
    `CHK("soft dens", 1'b0, density_pin)
    bus(1'b0, a_is, 8'h00);
    `CHK("soft prec", {~media_changed, 3'h0, 1'b0, 1'b1, 2'h1}, rd)
    set_mode(fhsdr_pkg::mode_c);
    `CHK("hard rate", fhsdr_pkg::rate_reset, rate_select)
  endtask
  task automatic t_modea();
    set_mode(fhsdr_pkg::mode_a);
    media_changed <= 1'b0;
    bus(1'b0, a_is, 8'h00);
    `CHK("media a", 1'b1, rd[7])
    `CHK("hiz a", 1'b1, oe_seen)
  endtask
  task automatic t_cmd();
    logic [7:0] op[2] = '{fhsdr_pkg::op_seek, fhsdr_pkg::op_recal};
    int         np[2] = '{2, 1};
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b <= np[k]; b++) begin
        wait_rqm();
        `CHK("direction", 1'b0, ms[fhsdr_pkg::ms_direction])
        `CHK("busy", b > 0, ms[fhsdr_pkg::ms_cmd_busy])
        bus(1'b1, a_dp, (b == 0) ? op[k] : 8'h00);
      end
      wait_rqm();
      `CHK("busy end", 1'b0, ms[fhsdr_pkg::ms_cmd_busy])
    end
  endtask
  task automatic t_write();
    bus(1'b1, a_is, {6'h00, fhsdr_pkg::rate_1m});
    bus(1'b1, a_dp, fhsdr_pkg::op_specify);
    bus(1'b1, a_dp, 8'h00);
    bus(1'b1, a_dp, 8'h01);
    bus(1'b1, a_dp, fhsdr_pkg::op_write);
    repeat (8) bus(1'b1, a_dp, 8'h00);
    wait_rqm();
    `CHK("exec st", 3'h3, ms[6:4])
    bus(1'b1, a_dp, 8'ha5);
    bus(1'b0, a_ms, 8'h00);
    `CHK("fifo off", 1'b0, rd[fhsdr_pkg::ms_request])
    while (dov !== 1'b1) @(posedge core_clk);
    `CHK("disk byte", 8'ha5, dout)
    @(posedge core_clk);
    while (dov !== 1'b1) @(posedge core_clk);
    `CHK("fill", fhsdr_pkg::fill_byte, dout)
    `CHK("crc", 1'b1, crc)
    results();
  endtask
  task automatic t_read();
    bus(1'b1, a_dp, fhsdr_pkg::op_read);
    repeat (8) bus(1'b1, a_dp, 8'h00);
    repeat (2 * fhsdr_pkg::byte_cyc_1m) @(posedge core_clk);
    bus(1'b0, a_ms, 8'h00);
    `CHK("drain", 4'hd, rd[7:4])
    bus(1'b0, a_dp, 8'h00);
    results();
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {avs_read, avs_write, media_changed, dma_gate, soft_reset} = 5'h00;
    {avs_address, avs_writedata} = '0;
    layout_mode = fhsdr_pkg::mode_b;
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK("reset rate", fhsdr_pkg::rate_reset, rate_select)
    `CHK("reset dens", 1'b1, density_pin)
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_unmapped();
    t_cmd();
    t_write();
    t_read();
    t_rates();
    t_modec();
    t_modea();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
